// *** rtl/dbg_pkg.sv ***
// shared constants for the debug freeze, protection and halt block
// assumes one core, one flash array and a probe on a serial debug link
// Contract
// - each timer, clock and watchdog may keep counting while halted
// - each timer, clock and watchdog may be frozen while halted
// - with its freeze bit set, CAN receive register holds while halted
// - with its freeze bit set, SMBus timeout detection pauses while halted
// - debugger writes to both freeze registers work during system reset
// - CPU software may also write both freeze registers
// - at level zero, the factory default, every flash access is allowed
// - at level one debug flash access faults and locks until power-on
// - at level one, SRAM code may still be loaded, run and debugged
// - lowering level one to level zero erases the whole flash
// - level two kills the debug link for good, never lowered again; here power-on reset returns it to level zero
// - CPU data reads of protected code areas are blocked, fetches run
// - debugger read of protected code raises flash NMI, returns pattern
// - single step into protected code is performed as a step over
// - writes and erases to write-protected sectors are rejected
// - breakpoint instruction halts the core for debugger inspection
// - breakpoint instruction without a debugger faults instead of halting
// - exception entry stacks the faulting address at SP plus 0x18
// - debug configuration and freeze registers survive a system reset
// - configuration bits keep the debug clock alive in low power modes
package dbg_pkg;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int CNT_W = 6;
	// link frame layout: start, write flag, select, data lsb first
	localparam logic [CNT_W-1:0] HDR_LAST = 6'h04;
	localparam logic [CNT_W-1:0] DATA_LAST = 6'h1F;
	localparam logic [CNT_W-1:0] RD_END = 6'h20;
	// register selects
	localparam logic [SEL_W-1:0] SEL_FZ1 = 4'h0;
	localparam logic [SEL_W-1:0] SEL_FZ2 = 4'h1;
	localparam logic [SEL_W-1:0] SEL_CFG = 4'h2;
	localparam logic [SEL_W-1:0] SEL_CTRL = 4'h3;
	localparam logic [SEL_W-1:0] SEL_PROT = 4'h4;
	localparam logic [SEL_W-1:0] SEL_MADDR = 4'h5;
	localparam logic [SEL_W-1:0] SEL_MDATA = 4'h6;
	localparam logic [SEL_W-1:0] SEL_STAT = 4'h7;
	// freeze register fields
	localparam int FZ_TIM_LSB = 0;
	localparam int FZ1_RTC = 10;
	localparam int FZ1_WWDG = 11;
	localparam int FZ1_IWDG = 12;
	localparam int FZ1_I2C = 21;
	localparam int FZ1_CAN = 25;
	// configuration, control and status fields
	localparam int CFG_SLEEP = 0;
	localparam int CFG_STOP = 1;
	localparam int CFG_STDBY = 2;
	localparam int CTRL_HALT = 0;
	localparam int CTRL_RESUME = 1;
	localparam int CTRL_STEP = 2;
	localparam int STAT_HALT = 0;
	localparam int STAT_LVL_LSB = 1;
	localparam int STAT_LOCK = 3;
	localparam int STAT_ATT = 4;
	// readout protection levels
	localparam logic [1:0] LVL0 = 2'h0;
	localparam logic [1:0] LVL1 = 2'h1;
	localparam logic [1:0] LVL2 = 2'h2;
	// reset values and fixed figures
	localparam logic [DATA_W-1:0] FZ_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PROP_PATTERN = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] STACK_PC_OFS = 32'h0000_0018;
	typedef enum logic [2:0] {L_IDLE, L_HDR, L_WDAT, L_WAIT, L_RDAT}
		link_state_t;
	typedef enum logic {S_IDLE, S_MEM} sys_state_t;
endpackage

// *** rtl/bit_sync.sv ***
// two-flop synchroniser for a single level or toggle
// assumes the input is held for at least two destination edges
module bit_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// level in, synchronised level out
	input wire logic d,
	output logic q
);
	logic meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // bit_sync

// *** rtl/dbg_link.sv ***
// serial debug link front end, runs entirely on the probe clock
// assumes the probe keeps clocking while it waits for read data
module dbg_link
	import dbg_pkg::*;
(
	// link clock and reset
	input wire logic swclk,
	input wire logic rstn,
	// serial data pin
	input wire logic swdio_in,
	output logic swdio_out,
	output logic swdio_oe,
	// handshake with the system side, already synchronised
	input wire logic link_en_s,
	input wire logic ack_s,
	input wire logic [DATA_W-1:0] rsp_data,
	output logic req_tgl,
	output logic cmd_wr,
	output logic [SEL_W-1:0] cmd_sel,
	output logic [DATA_W-1:0] cmd_data
);
	link_state_t st;
	logic [CNT_W-1:0] cnt;
	logic [DATA_W-1:0] sh;

	// frame receiver; command words stay still until the ack returns
	always_ff @(posedge swclk or negedge rstn) begin
		if (!rstn) begin
			st <= L_IDLE;
			cnt <= '0;
			sh <= '0;
			req_tgl <= 1'b0;
			cmd_wr <= 1'b0;
			cmd_sel <= '0;
			cmd_data <= '0;
			swdio_out <= 1'b0;
			swdio_oe <= 1'b0;
		end else begin
			case (st)
			L_IDLE: begin
				cnt <= '0;
				if (link_en_s && swdio_in)
					st <= L_HDR;
			end
			L_HDR: begin
				cnt <= cnt + 1'b1;
				if (cnt == '0)
					cmd_wr <= swdio_in;
				else
					cmd_sel <= {swdio_in, cmd_sel[SEL_W-1:1]};
				if (cnt == HDR_LAST) begin
					cnt <= '0;
					if (cmd_wr) begin
						st <= L_WDAT;
					end else begin
						req_tgl <= ~req_tgl;
						st <= L_WAIT;
					end
				end
			end
			L_WDAT: begin
				cnt <= cnt + 1'b1;
				cmd_data <= {swdio_in, cmd_data[DATA_W-1:1]};
				if (cnt == DATA_LAST) begin
					req_tgl <= ~req_tgl;
					st <= L_WAIT;
				end
			end
			L_WAIT: begin
				// ack equal to req means the system side is done
				if (ack_s == req_tgl) begin
					cnt <= '0;
					if (cmd_wr) begin
						st <= L_IDLE;
					end else begin
						sh <= rsp_data;
						swdio_out <= 1'b1;
						swdio_oe <= 1'b1;
						st <= L_RDAT;
					end
				end
			end
			L_RDAT: begin
				if (cnt == RD_END) begin
					swdio_oe <= 1'b0;
					swdio_out <= 1'b0;
					st <= L_IDLE;
				end else begin
					swdio_out <= sh[cnt[CNT_W-2:0]];
					cnt <= cnt + 1'b1;
				end
			end
			default: st <= L_IDLE;
			endcase
		end
	end
endmodule // dbg_link

// *** rtl/dbg_support.sv ***
// debug support: peripheral freeze, halt, readout and write protection
// assumes core, flash controller and peripherals sit on sys_clk;
// the probe link runs on swclk, unrelated in phase
module dbg_support
	import dbg_pkg::*;
#(
	parameter int N_TIM = 8,
	parameter int N_SECT = 32,
	parameter logic [DATA_W-1:0] FLASH_LO = 32'h1000_0000,
	parameter logic [DATA_W-1:0] FLASH_HI = 32'h1FFF_FFFF,
	parameter logic [DATA_W-1:0] EXT_LO = 32'h3000_0000,
	parameter logic [DATA_W-1:0] EXT_HI = 32'h3000_FFFF
) (
	// clocks and resets
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sys_rst_hold,
	input wire logic swclk,
	// serial debug pin
	input wire logic swdio_in,
	output logic swdio_out,
	output logic swdio_oe,
	// core halt and step
	input wire logic bp_exec,
	input wire logic [DATA_W-1:0] step_tgt_pc,
	output logic core_halt,
	output logic core_step,
	output logic core_step_over,
	output logic hard_fault,
	output logic exec_block,
	// cpu access to the freeze and configuration registers
	input wire logic cpu_reg_we,
	input wire logic [SEL_W-1:0] cpu_reg_sel,
	input wire logic [DATA_W-1:0] cpu_reg_wdata,
	// cpu data reads checked against protected code
	input wire logic cpu_rd,
	input wire logic [DATA_W-1:0] cpu_addr,
	input wire logic [DATA_W-1:0] prop_lo,
	input wire logic [DATA_W-1:0] prop_hi,
	output logic cpu_rd_deny,
	// debugger memory reads
	output logic dbg_mem_rd,
	output logic [DATA_W-1:0] dbg_mem_addr,
	input wire logic [DATA_W-1:0] dbg_mem_rdata,
	output logic flash_nmi,
	// flash programming
	input wire logic fl_wr_req,
	input wire logic [$clog2(N_SECT)-1:0] fl_sector,
	input wire logic [N_SECT-1:0] wprot_mask,
	output logic fl_wr_grant,
	output logic fl_wr_reject,
	output logic mass_erase,
	output logic [1:0] prot_level,
	// peripheral freezes
	output logic [2*N_TIM-1:0] tim_freeze,
	output logic rtc_freeze,
	output logic wwdg_freeze,
	output logic iwdg_freeze,
	output logic can_rx_freeze,
	output logic smbus_to_freeze,
	// exception stacking
	input wire logic exc_entry,
	input wire logic [DATA_W-1:0] core_sp,
	output logic [DATA_W-1:0] fault_pc_slot,
	// low power debug
	input wire logic lp_sleep,
	input wire logic lp_stop,
	input wire logic lp_stdby,
	output logic keep_dbg_clk
);
	if (N_TIM < 1 || N_TIM > 8) begin : g_bad_tim
		$error("N_TIM must lie in 1..8");
	end
	if (N_SECT < 2 || N_SECT > 256) begin : g_bad_sect
		$error("N_SECT must lie in 2..256");
	end

	function automatic logic in_rng(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	logic [DATA_W-1:0] fz1;
	logic [DATA_W-1:0] fz2;
	logic [DATA_W-1:0] cfg;
	logic [DATA_W-1:0] maddr;
	logic [DATA_W-1:0] rsp;
	logic [DATA_W-1:0] rd_val;
	logic [DATA_W-1:0] status;
	logic [2*N_TIM-1:0] tim_src;
	logic req_tgl;
	logic req_s;
	logic req_seen;
	logic ack_tgl;
	logic ack_s;
	logic link_en;
	logic link_en_s;
	logic cmd_wr;
	logic [SEL_W-1:0] cmd_sel;
	logic [DATA_W-1:0] cmd_data;
	logic attached;
	logic dbg_present;
	logic fault_lock;
	logic take;
	logic mem_rd_take;
	logic l1_hit;
	logic pc_hit;
	logic lwr;
	logic lower_req;
	sys_state_t sys_st;

	// probe-side logic on its own clock
	dbg_link u_link (
		.swclk(swclk),
		.rstn(rstn),
		.swdio_in(swdio_in),
		.swdio_out(swdio_out),
		.swdio_oe(swdio_oe),
		.link_en_s(link_en_s),
		.ack_s(ack_s),
		.rsp_data(rsp),
		.req_tgl(req_tgl),
		.cmd_wr(cmd_wr),
		.cmd_sel(cmd_sel),
		.cmd_data(cmd_data)
	);

	// toggles and the enable level cross through two flops each
	bit_sync u_req_sync (
		.clk(sys_clk),
		.rstn(rstn),
		.d(req_tgl),
		.q(req_s)
	);
	bit_sync u_ack_sync (
		.clk(swclk),
		.rstn(rstn),
		.d(ack_tgl),
		.q(ack_s)
	);
	bit_sync u_en_sync (
		.clk(swclk),
		.rstn(rstn),
		.d(link_en),
		.q(link_en_s)
	);

	// command decode; cmd words are stable once req_s has toggled
	assign take = (req_s != req_seen) && (sys_st == S_IDLE);
	assign lwr = take && cmd_wr;
	assign mem_rd_take = take && !cmd_wr && (cmd_sel == SEL_MDATA);
	assign l1_hit = mem_rd_take && (prot_level == LVL1) &&
		(in_rng(maddr, FLASH_LO, FLASH_HI) || in_rng(maddr, EXT_LO, EXT_HI));
	assign pc_hit = mem_rd_take && in_rng(maddr, prop_lo, prop_hi);
	assign lower_req = lwr && (cmd_sel == SEL_PROT) &&
		(prot_level == LVL1) && (cmd_data[1:0] == LVL0);
	assign dbg_present = attached && link_en;
	assign tim_src = {fz2[FZ_TIM_LSB +: N_TIM], fz1[FZ_TIM_LSB +: N_TIM]};

	// status word and read-back mux
	always_comb begin
		status = '0;
		status[STAT_HALT] = core_halt;
		status[STAT_LVL_LSB +: 2] = prot_level;
		status[STAT_LOCK] = fault_lock;
		status[STAT_ATT] = dbg_present;
		case (cmd_sel)
		SEL_FZ1: rd_val = fz1;
		SEL_FZ2: rd_val = fz2;
		SEL_CFG: rd_val = cfg;
		SEL_PROT: rd_val = {30'h0000_0000, prot_level};
		SEL_MADDR: rd_val = maddr;
		SEL_STAT: rd_val = status;
		default: rd_val = '0;
		endcase
	end

	// link command engine; memory reads wait one cycle for data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_seen <= 1'b0;
			ack_tgl <= 1'b0;
			rsp <= '0;
			maddr <= '0;
			sys_st <= S_IDLE;
			dbg_mem_rd <= 1'b0;
			dbg_mem_addr <= '0;
			flash_nmi <= 1'b0;
		end else begin
			dbg_mem_rd <= 1'b0;
			flash_nmi <= 1'b0;
			case (sys_st)
			S_IDLE: begin
				if (take) begin
					req_seen <= req_s;
					if (l1_hit) begin
						rsp <= '0;
						ack_tgl <= ~ack_tgl;
					end else if (pc_hit) begin
						rsp <= PROP_PATTERN;
						flash_nmi <= 1'b1;
						ack_tgl <= ~ack_tgl;
					end else if (mem_rd_take) begin
						dbg_mem_rd <= 1'b1;
						dbg_mem_addr <= maddr;
						sys_st <= S_MEM;
					end else begin
						rsp <= rd_val;
						ack_tgl <= ~ack_tgl;
						if (lwr && cmd_sel == SEL_MADDR)
							maddr <= cmd_data;
					end
				end
			end
			S_MEM: begin
				rsp <= dbg_mem_rdata;
				ack_tgl <= ~ack_tgl;
				sys_st <= S_IDLE;
			end
			default: sys_st <= S_IDLE;
			endcase
		end
	end

	// freeze and config registers: power-on reset only, so a system
	// reset neither clears them nor blocks writes; link wins a tie
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fz1 <= FZ_RESET;
			fz2 <= FZ_RESET;
			cfg <= CFG_RESET;
		end else if (lwr) begin
			if (cmd_sel == SEL_FZ1)
				fz1 <= cmd_data;
			if (cmd_sel == SEL_FZ2)
				fz2 <= cmd_data;
			if (cmd_sel == SEL_CFG)
				cfg <= cmd_data;
		end else if (cpu_reg_we) begin
			if (cpu_reg_sel == SEL_FZ1)
				fz1 <= cpu_reg_wdata;
			if (cpu_reg_sel == SEL_FZ2)
				fz2 <= cpu_reg_wdata;
			if (cpu_reg_sel == SEL_CFG)
				cfg <= cpu_reg_wdata;
		end
	end

	// a probe that has spoken once counts as connected
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			attached <= 1'b0;
		else if (take)
			attached <= 1'b1;
	end

	// halt state; a breakpoint halts only with a probe present
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			core_halt <= 1'b0;
		else if (sys_rst_hold)
			core_halt <= 1'b0;
		else if (bp_exec && dbg_present)
			core_halt <= 1'b1;
		else if (lwr && cmd_sel == SEL_CTRL && cmd_data[CTRL_RESUME])
			core_halt <= 1'b0;
		else if (lwr && cmd_sel == SEL_CTRL && cmd_data[CTRL_HALT])
			core_halt <= 1'b1;
	end

	// single step; protected code is stepped over, never entered
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			core_step <= 1'b0;
			core_step_over <= 1'b0;
		end else begin
			core_step <= 1'b0;
			core_step_over <= 1'b0;
			if (lwr && cmd_sel == SEL_CTRL && cmd_data[CTRL_STEP] &&
				core_halt) begin
				if (in_rng(step_tgt_pc, prop_lo, prop_hi))
					core_step_over <= 1'b1;
				else
					core_step <= 1'b1;
			end
		end
	end

	// faults; the lock ignores system reset, only power-on clears it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hard_fault <= 1'b0;
			fault_lock <= 1'b0;
		end else begin
			hard_fault <= l1_hit || (bp_exec && !dbg_present);
			if (l1_hit)
				fault_lock <= 1'b1;
		end
	end
	assign exec_block = fault_lock;

	// protection level; level two holds until power-on reset, dropping one erases
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prot_level <= LVL0;
			mass_erase <= 1'b0;
			link_en <= 1'b1;
		end else begin
			mass_erase <= lower_req;
			link_en <= (prot_level != LVL2);
			if (lwr && cmd_sel == SEL_PROT && prot_level != LVL2) begin
				if (cmd_data[1:0] == LVL2)
					prot_level <= LVL2;
				else if (cmd_data[1:0] == LVL1 || lower_req)
					prot_level <= cmd_data[1:0];
			end
		end
	end

	// cpu data reads of protected code refused; fetches never come here
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			cpu_rd_deny <= 1'b0;
		else
			cpu_rd_deny <= cpu_rd && in_rng(cpu_addr, prop_lo, prop_hi);
	end

	// flash write and erase gate
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fl_wr_grant <= 1'b0;
			fl_wr_reject <= 1'b0;
		end else begin
			fl_wr_grant <= fl_wr_req && !wprot_mask[fl_sector];
			fl_wr_reject <= fl_wr_req && wprot_mask[fl_sector];
		end
	end

	// freeze outputs follow halt, so they drop one cycle after resume
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tim_freeze <= '0;
			rtc_freeze <= 1'b0;
			wwdg_freeze <= 1'b0;
			iwdg_freeze <= 1'b0;
			can_rx_freeze <= 1'b0;
			smbus_to_freeze <= 1'b0;
		end else begin
			tim_freeze <= core_halt ? tim_src : '0;
			rtc_freeze <= core_halt && fz1[FZ1_RTC];
			wwdg_freeze <= core_halt && fz1[FZ1_WWDG];
			iwdg_freeze <= core_halt && fz1[FZ1_IWDG];
			can_rx_freeze <= core_halt && fz1[FZ1_CAN];
			smbus_to_freeze <= core_halt && fz1[FZ1_I2C];
		end
	end

	// stacked fault address slot for the handler
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			fault_pc_slot <= '0;
		else if (exc_entry)
			fault_pc_slot <= core_sp + STACK_PC_OFS;
	end

	// keep the debug clock in low power only where configured
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			keep_dbg_clk <= 1'b0;
		else
			keep_dbg_clk <= (lp_sleep && cfg[CFG_SLEEP]) ||
				(lp_stop && cfg[CFG_STOP]) || (lp_stdby && cfg[CFG_STDBY]);
	end

	default clocking cb_sys @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_bp_hosted;
		bp_exec && dbg_present && !sys_rst_hold;
	endsequence
	sequence s_lock_held;
		exec_block [*3];
	endsequence

	property p_frz_tim;
		core_halt |=> tim_freeze == $past(tim_src);
	endproperty
	a_frz_tim: assert property (p_frz_tim)
		else $error("timer freeze does not follow bits while halted");

	property p_run_free;
		!core_halt |=> tim_freeze == '0 && !rtc_freeze && !wwdg_freeze &&
			!iwdg_freeze && !can_rx_freeze && !smbus_to_freeze;
	endproperty
	a_run_free: assert property (p_run_free)
		else $error("freeze active while core runs");

	property p_can;
		core_halt && fz1[FZ1_CAN] |=> can_rx_freeze;
	endproperty
	a_can: assert property (p_can)
		else $error("CAN receive not frozen during halt");

	property p_smb;
		core_halt && fz1[FZ1_I2C] |=> smbus_to_freeze;
	endproperty
	a_smb: assert property (p_smb)
		else $error("SMBus timeout not held during halt");

	property p_rst_wr;
		sys_rst_hold && lwr && cmd_sel == SEL_FZ1 |=> fz1 == $past(cmd_data);
	endproperty
	a_rst_wr: assert property (p_rst_wr)
		else $error("link write lost under system reset");

	property p_cpu_wr;
		cpu_reg_we && cpu_reg_sel == SEL_FZ2 && !lwr |=>
			fz2 == $past(cpu_reg_wdata);
	endproperty
	a_cpu_wr: assert property (p_cpu_wr)
		else $error("cpu write to freeze register lost");

	property p_keep;
		sys_rst_hold && !lwr && !cpu_reg_we |=> $stable(fz1) && $stable(cfg);
	endproperty
	a_keep: assert property (p_keep)
		else $error("debug registers changed by system reset");

	property p_mem_ok;
		mem_rd_take && !l1_hit && !pc_hit |=>
			dbg_mem_rd && dbg_mem_addr == $past(maddr);
	endproperty
	a_mem_ok: assert property (p_mem_ok)
		else $error("allowed debugger read not issued");

	property p_l1_lock;
		l1_hit |=> hard_fault && !dbg_mem_rd ##0 s_lock_held;
	endproperty
	a_l1_lock: assert property (p_l1_lock)
		else $error("level one debug flash access did not lock");

	property p_erase;
		lower_req |=> mass_erase && prot_level == LVL0;
	endproperty
	a_erase: assert property (p_erase)
		else $error("lowering protection did not erase flash");

	property p_l2;
		prot_level == LVL2 |=> prot_level == LVL2 && !link_en;
	endproperty
	a_l2: assert property (p_l2)
		else $error("level two lowered or link still enabled");

	property p_prop_cpu;
		cpu_rd && in_rng(cpu_addr, prop_lo, prop_hi) |=> cpu_rd_deny;
	endproperty
	a_prop_cpu: assert property (p_prop_cpu)
		else $error("cpu read of protected code not denied");

	property p_prop_dbg;
		pc_hit && !l1_hit |=> flash_nmi && rsp == PROP_PATTERN && !dbg_mem_rd;
	endproperty
	a_prop_dbg: assert property (p_prop_dbg)
		else $error("debugger read of protected code not trapped");

	property p_step;
		core_step_over |-> !core_step && $past(core_halt);
	endproperty
	a_step: assert property (p_step)
		else $error("step over without a halted core");

	property p_wprot;
		fl_wr_req && wprot_mask[fl_sector] |=> fl_wr_reject && !fl_wr_grant;
	endproperty
	a_wprot: assert property (p_wprot)
		else $error("write to protected sector not rejected");

	property p_bp_halt;
		s_bp_hosted |=> core_halt && !hard_fault;
	endproperty
	a_bp_halt: assert property (p_bp_halt)
		else $error("breakpoint with probe did not halt");

	property p_bp_fault;
		bp_exec && !dbg_present && !core_halt |=> hard_fault && !core_halt;
	endproperty
	a_bp_fault: assert property (p_bp_fault)
		else $error("breakpoint without probe did not fault");

	property p_stack;
		exc_entry |=> fault_pc_slot == $past(core_sp) + 32'h0000_0018;
	endproperty
	a_stack: assert property (p_stack)
		else $error("fault address slot is not SP plus 0x18");

	property p_lp;
		lp_stop && cfg[CFG_STOP] |=> keep_dbg_clk;
	endproperty
	a_lp: assert property (p_lp)
		else $error("debug clock dropped in configured stop mode");
endmodule // dbg_support

// *** verif/dbg_probe.sv ***
// probe model for the serial debug link: frames, reads and writes
// assumes pin is the resolved wire level fed back from the bench
module dbg_probe (
	// link clock and probe drive
	output logic swclk,
	output logic pdrv,
	// resolved pin level
	input wire logic pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock stands low between frames
	initial begin
		swclk = 1'b0;
		pdrv = 1'b0;
	end
	// one bit: change on fall, sample just before the rise
	task automatic bt(input logic b, output logic s);
		pdrv = b;
		#62 s = pin;
		#0.5 swclk = 1'b1;
		#62.5 swclk = 1'b0;
	endtask
	// idle edges let the enable sync settle, then start, flag, select
	task automatic hdr(input logic w, input logic [3:0] sel);
		logic s;
		repeat (4) bt(1'b0, s);
		bt(1'b1, s);
		bt(w, s);
		for (int i = 0; i < 4; i++) bt(sel[i], s);
	endtask
	// write frame, keeps clocking until the ack has crossed back
	task automatic wr(input logic [3:0] sel, input logic [31:0] d);
		logic s;
		hdr(1'b1, sel);
		for (int i = 0; i < 32; i++) bt(d[i], s);
		repeat (8) bt(1'b0, s);
	endtask
	// read frame, bounded wait for the marker; no marker gives zero
	task automatic rd(input logic [3:0] sel, output logic [31:0] d);
		logic s;
		int n;
		hdr(1'b0, sel);
		d = 32'h0;
		s = 1'b0;
		n = 0;
		while (!s && n < 20) begin
			bt(1'b0, s);
			n++;
		end
		if (s) begin
			for (int i = 0; i < 32; i++) bt(1'b0, d[i]);
		end
		repeat (2) bt(1'b0, s);
	endtask
endmodule // dbg_probe

// *** verif/debug_freeze_and_protection_tb_top.sv ***
// bench for the debug freeze, halt and protection block
// assumes dbg_support on sys_clk and the probe model on its own clock
module debug_freeze_and_protection_tb_top import dbg_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] FZV = 32'h0220_140F;
	logic sys_clk, rstn, sys_rst_hold, swclk, swdio_in, swdio_out, swdio_oe;
	logic bp_exec, core_halt, core_step, core_step_over, hard_fault;
	logic exec_block, cpu_reg_we, cpu_rd, cpu_rd_deny, dbg_mem_rd, flash_nmi;
	logic fl_wr_req, fl_wr_grant, fl_wr_reject, mass_erase, rtc_freeze;
	logic wwdg_freeze, iwdg_freeze, can_rx_freeze, smbus_to_freeze;
	logic exc_entry, lp_sleep, lp_stop, lp_stdby, keep_dbg_clk, pdrv;
	logic [SEL_W-1:0] cpu_reg_sel;
	logic [4:0] fl_sector;
	logic [1:0] prot_level;
	logic [15:0] tim_freeze;
	logic [31:0] wprot_mask, step_tgt_pc, cpu_reg_wdata, cpu_addr, prop_lo;
	logic [31:0] prop_hi, dbg_mem_addr, dbg_mem_rdata, core_sp, fault_pc_slot;
	logic [31:0] rd_v;
	int fail_count, cmp_count, nhf, nnmi, nme, nso, nrej, ngr, nst, nmr;
	// pin level from both drivers; memory answers the inverted address
	assign swdio_in = swdio_oe ? swdio_out : pdrv;
	assign dbg_mem_rdata = ~dbg_mem_addr;
	dbg_support dut_u (.sys_clk, .rstn, .sys_rst_hold, .swclk, .swdio_in,
		.swdio_out, .swdio_oe, .bp_exec, .step_tgt_pc, .core_halt,
		.core_step, .core_step_over, .hard_fault, .exec_block, .cpu_reg_we,
		.cpu_reg_sel, .cpu_reg_wdata, .cpu_rd, .cpu_addr, .prop_lo, .prop_hi,
		.cpu_rd_deny, .dbg_mem_rd, .dbg_mem_addr, .dbg_mem_rdata,
		.flash_nmi, .fl_wr_req, .fl_sector, .wprot_mask, .fl_wr_grant,
		.fl_wr_reject, .mass_erase, .prot_level, .tim_freeze, .rtc_freeze,
		.wwdg_freeze, .iwdg_freeze, .can_rx_freeze, .smbus_to_freeze,
		.exc_entry, .core_sp, .fault_pc_slot, .lp_sleep, .lp_stop, .lp_stdby,
		.keep_dbg_clk);
	dbg_probe p_u (.swclk, .pdrv, .pin(swdio_in));
	// system clock
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;
	// pulse counters, since one-cycle pulses are easy to miss
	always @(posedge sys_clk) begin
		nhf += hard_fault;
		nnmi += flash_nmi;
		nme += mass_erase;
		nso += core_step_over;
		nrej += fl_wr_reject;
		ngr += fl_wr_grant;
		nst += core_step;
		nmr += dbg_mem_rd;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic cpuw(input logic [3:0] s, input logic [31:0] d);
		cyc(1);
		{cpu_reg_we, cpu_reg_sel, cpu_reg_wdata} = {1'b1, s, d};
		cyc(1);
		cpu_reg_we = 1'b0;
	endtask
	task automatic flw(input logic [4:0] s);
		cyc(1);
		{fl_wr_req, fl_sector} = {1'b1, s};
		cyc(1);
		fl_wr_req = 1'b0;
	endtask
	task automatic bp();
		cyc(1);
		bp_exec = 1'b1;
		cyc(1);
		bp_exec = 1'b0;
		cyc(2);
	endtask
	task automatic mrd(input logic [31:0] a);
		p_u.wr(SEL_MADDR, a);
		p_u.rd(SEL_MDATA, rd_v);
		cyc(1);
	endtask
	// hang guard
	initial begin
		#300us;
		fail_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{rstn, sys_rst_hold, bp_exec, cpu_reg_we, cpu_rd, fl_wr_req} = '0;
		{exc_entry, lp_sleep, lp_stop, lp_stdby, cpu_reg_sel} = '0;
		{step_tgt_pc, cpu_reg_wdata, cpu_addr, core_sp, fl_sector} = '0;
		{prop_lo, prop_hi} = {32'h1000_8000, 32'h1000_8FFF};
		wprot_mask = 32'h0000_0020;
		cyc(3);
		rstn = 1'b1;
		cyc(2);
		chk(prot_level, LVL0);
		chk(tim_freeze, 32'h0);
		sys_rst_hold = 1'b1;
		p_u.wr(SEL_FZ1, FZV);
		cyc(1);
		sys_rst_hold = 1'b0;
		p_u.rd(SEL_FZ1, rd_v);
		chk(rd_v, FZV);
		cpuw(SEL_FZ2, 32'h0000_00F0);
		bp();
		chk(core_halt, 1'b1);
		chk(tim_freeze, 32'hF00F);
		chk({rtc_freeze, wwdg_freeze, iwdg_freeze}, 32'h5);
		chk(can_rx_freeze, 1'b1);
		chk(smbus_to_freeze, 1'b1);
		p_u.rd(SEL_STAT, rd_v);
		chk(rd_v, 32'h11);
		step_tgt_pc = 32'h1000_8010;
		p_u.wr(SEL_CTRL, 32'h4);
		cyc(2);
		chk(nso, 1);
		step_tgt_pc = 32'h2000_0000;
		p_u.wr(SEL_CTRL, 32'h4);
		cyc(2);
		chk(nst, 1);
		p_u.wr(SEL_CTRL, 32'h2);
		cyc(2);
		chk({core_halt, tim_freeze, can_rx_freeze}, 32'h0);
		p_u.wr(SEL_CTRL, 32'h1);
		cyc(2);
		chk({core_halt, can_rx_freeze}, 32'h3);
		sys_rst_hold = 1'b1;
		cyc(2);
		sys_rst_hold = 1'b0;
		chk({core_halt, can_rx_freeze}, 32'h0);
		p_u.rd(SEL_FZ1, rd_v);
		chk(rd_v, FZV);
		flw(5'h05);
		flw(5'h06);
		cyc(1);
		chk({nrej[7:0], ngr[7:0]}, 32'h0101);
		core_sp = 32'h2000_0100;
		exc_entry = 1'b1;
		cyc(1);
		exc_entry = 1'b0;
		chk(fault_pc_slot, 32'h2000_0118);
		{cpu_rd, cpu_addr} = {1'b1, 32'h1000_8004};
		cyc(1);
		cpu_rd = 1'b0;
		chk(cpu_rd_deny, 1'b1);
		mrd(32'h1000_8000);
		chk(rd_v, PROP_PATTERN);
		chk(nnmi, 1);
		cpuw(SEL_CFG, 32'h3);
		lp_sleep = 1'b1;
		cyc(2);
		chk(keep_dbg_clk, 1'b1);
		{lp_sleep, lp_stop} = 2'b01;
		cyc(2);
		chk(keep_dbg_clk, 1'b1);
		{lp_stop, lp_stdby} = 2'b01;
		cyc(2);
		chk(keep_dbg_clk, 1'b0);
		p_u.wr(SEL_PROT, 32'h1);
		mrd(32'h2000_0040);
		chk(rd_v, 32'hDFFF_FFBF);
		mrd(32'h1000_0000);
		chk(rd_v, 32'h0);
		chk({nmr[3:0], nhf[3:0]}, 32'h11);
		sys_rst_hold = 1'b1;
		cyc(2);
		sys_rst_hold = 1'b0;
		chk(exec_block, 1'b1);
		p_u.wr(SEL_PROT, 32'h0);
		chk({nme[3:0], prot_level}, {4'h1, LVL0});
		p_u.wr(SEL_PROT, 32'h2);
		p_u.wr(SEL_PROT, 32'h0);
		chk(prot_level, LVL2);
		p_u.rd(SEL_STAT, rd_v);
		chk(rd_v, 32'h0);
		bp();
		chk({core_halt, nhf[3:0]}, 32'h2);
		tally_and_finish();
	end
endmodule // debug_freeze_and_protection_tb_top
